// [rtl/cache_policy_controller.sv]
// Cache policy controller: CPU lookup, line transfers to memory, policy registers
//
// How it works
// - Write-through mode sends every CPU write hit to memory at once.
// - Write-through mode stalls the CPU until that memory write is acknowledged.
// - Copy-back store hits update only the cache, no memory write.
// - Copy-back writes a line back only when dirty and chosen as victim.
// - Each line keeps a dirty bit, set when a copy-back store modifies it.
// - Write-allocate miss fills the line first, then applies the write data.
// - No-allocate write miss goes to memory only; cache and tags untouched.
// - Direct mapping uses one line per address, always the victim.
// - Set-associative mode picks the victim way by the configured method.
// - LRU tracks use order per set, evicts least recently referenced way.
// - FIFO tracks load order per set, evicts the earliest filled way.
// - Random mode picks the victim from a pseudo-random source.
// - Demand fills are requested only on a CPU miss.
// - Prefetch fills the next line only in memory cycles the CPU leaves idle.
// - Fills and write-backs move one whole line each.
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cache_policy_controller
   import cpc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic cpu_req_in,
   input wire cpu_cmd_s cpu_cmd_in,
   output logic cpu_ready_out,
   output logic cpu_done_out,
   output logic [`CPC_DATA_W-1:0] cpu_rdata_out,
   output mem_cmd_s mem_cmd_out,
   input wire logic mem_ack_in,
   input wire logic [`CPC_LINE_W-1:0] mem_rline_in,
   input wire logic [`CPC_REG_A_W-1:0] reg_addr_in,
   input wire logic [`CPC_REG_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [`CPC_REG_W-1:0] reg_rdata_out
);
   // Storage arrays; only valid and dirty need a reset
   logic [`CPC_TAG_W-1:0] tag_q [`CPC_WAYS][`CPC_SETS];
   logic [`CPC_LINE_W-1:0] data_q [`CPC_WAYS][`CPC_SETS];
   logic [`CPC_WAYS-1:0][`CPC_SETS-1:0] valid_q;
   logic [`CPC_WAYS-1:0][`CPC_SETS-1:0] dirty_q;

   state_e state_q;
   state_e state_d;
   cpu_cmd_s req_q;
   mem_cmd_s mcmd_q;
   mem_cmd_s mcmd_d;
   logic [`CPC_CTRL_W-1:0] ctrl_q;
   logic vway_q;
   logic refill_q;
   logic pf_pend_q;
   logic [`CPC_LINE_A_W-1:0] pf_line_q;
   logic done_q;
   logic [`CPC_DATA_W-1:0] rdata_q;
   logic [`CPC_REG_W-1:0] hits_q;
   logic [`CPC_REG_W-1:0] miss_q;
   logic [`CPC_REG_W-1:0] reg_rdata_q;
   ctrl_s ctrl;
   logic direct;

   function automatic logic [`CPC_IDX_W-1:0] set_of(input logic [`CPC_ADDR_W-1:0] a);
      return a[`CPC_IDX_W+`CPC_BOFS_W-1:`CPC_BOFS_W];
   endfunction

   function automatic logic [`CPC_TAG_W-1:0] tag_of(input logic [`CPC_ADDR_W-1:0] a);
      return a[`CPC_ADDR_W-1:`CPC_IDX_W+`CPC_BOFS_W];
   endfunction

   // Returns {hit, way}; way 1 is blind in direct mode. Tags and valid bits come in as
   // arguments so the assignments that call it wake up when a fill changes the arrays
   function automatic logic [1:0] probe(input logic [`CPC_TAG_W-1:0] t, input logic dm,
                                        input logic v0, input logic [`CPC_TAG_W-1:0] t0,
                                        input logic v1, input logic [`CPC_TAG_W-1:0] t1);
      logic h0;
      logic h1;
      h0 = v0 && (t0 == t);
      h1 = !dm && v1 && (t1 == t);
      return {h0 | h1, h1};
   endfunction

   function automatic logic [`CPC_LINE_W-1:0] line_put(input logic [`CPC_LINE_W-1:0] l,
                                                      input logic [1:0] w, input logic [`CPC_DATA_W-1:0] d);
      logic [`CPC_LINE_W-1:0] r;
      r = l;
      r[w*`CPC_DATA_W +: `CPC_DATA_W] = d;
      return r;
   endfunction

   function automatic mem_cmd_s mk_cmd(input logic we, input logic [`CPC_LINE_A_W-1:0] line,
                                       input logic [`CPC_WORDS-1:0] mask, input logic [`CPC_LINE_W-1:0] d);
      mem_cmd_s c;
      c.req = 1'b1;
      c.we = we;
      c.line = line;
      c.mask = mask;
      c.data = d;
      return c;
   endfunction

   assign ctrl = ctrl_s'(ctrl_q);
   assign direct = (ctrl.repl == REPL_DIRECT);

   // Lookup of the held CPU request
   wire [`CPC_IDX_W-1:0] set = set_of(req_q.addr);
   wire [1:0] cpu_probe = probe(tag_of(req_q.addr), direct, valid_q[0][set], tag_q[0][set],
                                valid_q[1][set], tag_q[1][set]);
   wire hit = cpu_probe[1];
   wire hway = cpu_probe[0];
   wire [1:0] wsel = req_q.addr[`CPC_BOFS_W-1:2];
   wire [`CPC_LINE_A_W-1:0] req_line = req_q.addr[`CPC_ADDR_W-1:`CPC_BOFS_W];

   // Prefetch candidate lookup
   wire [`CPC_ADDR_W-1:0] pf_addr = {pf_line_q, {`CPC_BOFS_W{1'b0}}};
   wire [`CPC_IDX_W-1:0] pf_set = set_of(pf_addr);
   wire [1:0] pf_probe = probe(tag_of(pf_addr), direct, valid_q[0][pf_set], tag_q[0][pf_set],
                               valid_q[1][pf_set], tag_q[1][pf_set]);

   // Victim choice; outside direct mode an empty way is taken first
   wire in_look = (state_q == ST_LOOK);
   wire [`CPC_IDX_W-1:0] vic_set = in_look ? set : pf_set;
   wire vic_pick;
   wire vway_w = direct ? 1'b0 :
                 !valid_q[0][vic_set] ? 1'b0 :
                 !valid_q[1][vic_set] ? 1'b1 : vic_pick;
   // Only copy-back sets dirty bits; not gating on the mode keeps them flushed after a switch
   wire vic_dirty = valid_q[vway_w][vic_set] && dirty_q[vway_w][vic_set];

   // Events of the lookup cycle
   wire look_hit = in_look && hit;
   wire rd_hit = look_hit && !req_q.we;
   wire wr_hit = look_hit && req_q.we;
   wire miss = in_look && !hit;
   wire miss_nowa = miss && req_q.we && !ctrl.wa;
   wire need_wb = vic_dirty;

   // Fill completion, demand or prefetch
   wire in_pf = (state_q == ST_PF);
   wire fill_done = ((state_q == ST_FILL) || in_pf) && mem_ack_in;
   wire [`CPC_ADDR_W-1:0] fill_addr = in_pf ? pf_addr : req_q.addr;
   wire [`CPC_IDX_W-1:0] fill_set = set_of(fill_addr);

   // Prefetch only while the CPU leaves the memory idle
   wire pf_slot = (state_q == ST_IDLE) && !cpu_req_in && pf_pend_q;
   wire pf_go = pf_slot && ctrl.pf && !pf_probe[1] && !vic_dirty;
   wire wt_ack = (state_q == ST_WT) && mem_ack_in;
   wire done_w = rd_hit || (wr_hit && ctrl.cb) || wt_ack;

   cpc_victim u_victim (
      .mclk_in(mclk_in),
      .rst_b_in(rst_b_in),
      .mode_in(ctrl.repl),
      .set_in(vic_set),
      .use_in(look_hit),
      .fill_in(fill_done),
      .upd_set_in(fill_done ? fill_set : set),
      .upd_way_in(fill_done ? vway_q : hway),
      .way_out(vic_pick)
   );

   // Sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (cpu_req_in) begin
               state_d = ST_LOOK;
            end else if (pf_go) begin
               state_d = ST_PF;
            end
         end
         ST_LOOK: begin
            if (wr_hit && !ctrl.cb) begin
               state_d = ST_WT;
            end else if (look_hit) begin
               state_d = ST_IDLE;
            end else if (miss_nowa) begin
               state_d = ST_WT;
            end else if (need_wb) begin
               state_d = ST_WB;
            end else begin
               state_d = ST_FILL;
            end
         end
         ST_WB: if (mem_ack_in) state_d = ST_FILL;
         ST_FILL: if (mem_ack_in) state_d = ST_LOOK;
         ST_WT: if (mem_ack_in) state_d = ST_IDLE;
         ST_PF: if (mem_ack_in) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // Memory command for the state being entered; whole lines except the word write
   wire enter = (state_d != state_q);
   wire [`CPC_LINE_A_W-1:0] wb_line = {tag_q[vway_w][set], set};
   wire mem_cmd_s wb_cmd = mk_cmd(1'b1, wb_line, `CPC_MASK_ALL, data_q[vway_w][set]);
   wire mem_cmd_s fill_cmd = mk_cmd(1'b0, req_line, `CPC_MASK_ALL, '0);
   wire mem_cmd_s wt_cmd = mk_cmd(1'b1, req_line, `CPC_MASK_ONE << wsel, {`CPC_WORDS{req_q.wdata}});
   wire mem_cmd_s pf_cmd = mk_cmd(1'b0, pf_line_q, `CPC_MASK_ALL, '0);
   assign mcmd_d = !enter ? mcmd_q :
                   (state_d == ST_WB) ? wb_cmd :
                   (state_d == ST_FILL) ? fill_cmd :
                   (state_d == ST_WT) ? wt_cmd :
                   (state_d == ST_PF) ? pf_cmd : '0;

   // Sequencer, request and memory command registers
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= ST_IDLE;
         req_q <= '0;
         mcmd_q <= '0;
         vway_q <= 1'b0;
      end else begin
         state_q <= state_d;
         mcmd_q <= mcmd_d;
         if (cpu_req_in && cpu_ready_out) req_q <= cpu_cmd_in;
         if (miss || pf_go) vway_q <= vway_w;
      end
   end

   // Line data and tags; no reset, valid bits guard them
   always_ff @(posedge mclk_in) begin
      if (fill_done) begin
         data_q[vway_q][fill_set] <= mem_rline_in;
         tag_q[vway_q][fill_set] <= tag_of(fill_addr);
      end else if (wr_hit) begin
         data_q[hway][set] <= line_put(data_q[hway][set], wsel, req_q.wdata);
      end
   end

   // Valid and dirty bits
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         valid_q <= '0;
         dirty_q <= '0;
      end else if (fill_done) begin
         valid_q[vway_q][fill_set] <= 1'b1;
         dirty_q[vway_q][fill_set] <= 1'b0;
      end else if (wr_hit && ctrl.cb) begin
         dirty_q[hway][set] <= 1'b1;
      end
   end

   // Next-line prefetch bookkeeping; a demand fill arms it
   wire pf_arm = (state_q == ST_FILL) && mem_ack_in;
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         pf_pend_q <= 1'b0;
         pf_line_q <= '0;
         refill_q <= 1'b0;
      end else begin
         if (pf_arm) begin
            pf_pend_q <= 1'b1;
            pf_line_q <= req_line + `CPC_LINE_A_W'(1);
         end else if (pf_slot) begin
            pf_pend_q <= 1'b0;
         end
         refill_q <= pf_arm;
      end
   end

   // CPU answer; read data held until the next read hit
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         done_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         done_q <= done_w;
         if (rd_hit) rdata_q <= data_q[hway][set][wsel*`CPC_DATA_W +: `CPC_DATA_W];
      end
   end

   // Hit and miss counters; the lookup after a fill is not a second hit
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         hits_q <= '0;
         miss_q <= '0;
      end else begin
         if (look_hit && !refill_q) hits_q <= hits_q + `CPC_REG_W'(1);
         if (miss) miss_q <= miss_q + `CPC_REG_W'(1);
      end
   end

   // Register port: control is writable, the rest read only
   wire ctrl_sel = (reg_addr_in == `CPC_CTRL_OFS);
   wire [`CPC_REG_W-1:0] stat_w = `CPC_REG_W'({pf_pend_q, state_q != ST_IDLE, state_q});
   wire [`CPC_REG_W-1:0] reg_mux = ctrl_sel ? `CPC_REG_W'(ctrl_q) :
                                   (reg_addr_in == `CPC_STAT_OFS) ? stat_w :
                                   (reg_addr_in == `CPC_HITS_OFS) ? hits_q :
                                   (reg_addr_in == `CPC_MISS_OFS) ? miss_q : '0;
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctrl_q <= `CPC_CTRL_RST;
         reg_rdata_q <= '0;
      end else begin
         if (reg_wr_in && ctrl_sel) ctrl_q <= reg_wdata_in[`CPC_CTRL_W-1:0];
         reg_rdata_q <= reg_rd_in ? reg_mux : '0;
      end
   end

   // Ready is combinational so a new request can follow a done with no gap
   assign cpu_ready_out = (state_q == ST_IDLE);
   assign cpu_done_out = done_q;
   assign cpu_rdata_out = rdata_q;
   assign mem_cmd_out = mcmd_q;
   assign reg_rdata_out = reg_rdata_q;
endmodule // cache_policy_controller

// [shared/cpc_defs.svh]
// Widths, register offsets, reset values and seeds of the cache policy controller
`ifndef CPC_DEFS_SVH
`define CPC_DEFS_SVH
`define CPC_ADDR_W 32
`define CPC_DATA_W 32
`define CPC_WAYS 2
`define CPC_SETS 16
`define CPC_IDX_W 4
`define CPC_BOFS_W 4
`define CPC_TAG_W 24
`define CPC_LINE_A_W 28
`define CPC_WORDS 4
`define CPC_LINE_W 128
`define CPC_REG_A_W 8
`define CPC_REG_W 32
`define CPC_CTRL_OFS 8'h00
`define CPC_STAT_OFS 8'h04
`define CPC_HITS_OFS 8'h08
`define CPC_MISS_OFS 8'h0C
`define CPC_CTRL_W 5
`define CPC_CTRL_RST 5'h02
`define CPC_LFSR_W 8
`define CPC_LFSR_SEED 8'hA5
`define CPC_MASK_ALL 4'hF
`define CPC_MASK_ONE 4'h1
`endif

// [shared/cpc_pkg.sv]
// Types shared by the cache policy controller and its victim selector
`include "cpc_defs.svh"
package cpc_pkg;
   typedef enum logic [1:0] {REPL_DIRECT, REPL_LRU, REPL_FIFO, REPL_RANDOM} repl_e;

   typedef enum logic [2:0] {ST_IDLE, ST_LOOK, ST_WB, ST_FILL, ST_WT, ST_PF} state_e;

   // Control word, bit 0 first from the right
   typedef struct packed {
      logic pf;
      repl_e repl;
      logic wa;
      logic cb;
   } ctrl_s;

   typedef struct packed {
      logic we;
      logic [`CPC_ADDR_W-1:0] addr;
      logic [`CPC_DATA_W-1:0] wdata;
   } cpu_cmd_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [`CPC_LINE_A_W-1:0] line;
      logic [`CPC_WORDS-1:0] mask;
      logic [`CPC_LINE_W-1:0] data;
   } mem_cmd_s;
endpackage

// [rtl/cpc_victim.sv]
// Replacement state per set and choice of the victim way
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cpc_victim
   import cpc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire repl_e mode_in,
   input wire logic [`CPC_IDX_W-1:0] set_in,
   input wire logic use_in,
   input wire logic fill_in,
   input wire logic [`CPC_IDX_W-1:0] upd_set_in,
   input wire logic upd_way_in,
   output logic way_out
);
   logic [`CPC_SETS-1:0] lru_q;
   logic [`CPC_SETS-1:0] lru_d;
   logic [`CPC_SETS-1:0] fifo_q;
   logic [`CPC_SETS-1:0] fifo_d;
   logic [`CPC_LFSR_W-1:0] lfsr_q;
   logic [`CPC_LFSR_W-1:0] lfsr_d;
   logic rnd_bit;

   function automatic logic [`CPC_SETS-1:0] put_bit(input logic [`CPC_SETS-1:0] v,
                                                    input logic [`CPC_IDX_W-1:0] i, input logic b);
      logic [`CPC_SETS-1:0] r;
      r = v;
      r[i] = b;
      return r;
   endfunction

   // Each bit names the way to evict next in its set
   assign lru_d = (use_in || fill_in) ? put_bit(lru_q, upd_set_in, ~upd_way_in) : lru_q;
   assign fifo_d = fill_in ? put_bit(fifo_q, upd_set_in, ~upd_way_in) : fifo_q;
   // Free-running source, blind to use and age
   assign lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
   assign rnd_bit = lfsr_q[0];

   // Direct mapping has one candidate, so no choice at all
   assign way_out = (mode_in == REPL_LRU) ? lru_q[set_in] :
                    (mode_in == REPL_FIFO) ? fifo_q[set_in] :
                    (mode_in == REPL_RANDOM) ? rnd_bit : 1'b0;

   // Replacement history cleared at reset
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lru_q <= '0;
         fifo_q <= '0;
         lfsr_q <= `CPC_LFSR_SEED;
      end else begin
         lru_q <= lru_d;
         fifo_q <= fifo_d;
         lfsr_q <= lfsr_d;
      end
   end
endmodule // cpc_victim

// [bench/cpc_mem_model.sv]
// Line-wide main memory model that answers after a chosen latency
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cpc_mem_model
   import cpc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire mem_cmd_s cmd_in,
   input wire logic [3:0] lat_in,
   output logic ack_out,
   output logic [`CPC_LINE_W-1:0] rline_out
);
   logic [`CPC_LINE_W-1:0] store_q [logic [`CPC_LINE_A_W-1:0]];
   logic [`CPC_LINE_W-1:0] cur;
   logic [3:0] wait_q;
   wire [`CPC_LINE_A_W-1:0] ln = cmd_in.line;
   // Unwritten word i reads {i, line}; bus toggles outside read ack cycles
   always @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ack_out <= 1'h0;
         wait_q <= 4'h0;
         rline_out <= '0;
      end else begin
         ack_out <= 1'h0;
         rline_out <= ~rline_out;
         if (cmd_in.req && !ack_out && wait_q < lat_in) begin
            wait_q <= wait_q + 4'h1;
         end else if (cmd_in.req && !ack_out) begin
            wait_q <= 4'h0;
            ack_out <= 1'h1;
            cur = store_q.exists(ln) ? store_q[ln] : {4'h3, ln, 4'h2, ln, 4'h1, ln, 4'h0, ln};
            for (int i = 0; i < `CPC_WORDS; i++) begin
               if (cmd_in.we && cmd_in.mask[i]) cur[32*i +: 32] = cmd_in.data[32*i +: 32];
            end
            if (cmd_in.we) store_q[ln] = cur;
            else rline_out <= cur;
         end
      end
   end
endmodule // cpc_mem_model

// [bench/cpc_props.sv]
// Port-level checker of the cache policy controller
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cpc_checker
   import cpc_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_b_in,
   input wire logic cpu_req_in,
   input wire cpu_cmd_s cpu_cmd_in,
   input wire logic cpu_ready_out,
   input wire logic cpu_done_out,
   input wire logic [`CPC_DATA_W-1:0] cpu_rdata_out,
   input wire mem_cmd_s mem_cmd_out,
   input wire logic mem_ack_in,
   input wire logic [`CPC_LINE_W-1:0] mem_rline_in,
   input wire logic [`CPC_REG_A_W-1:0] reg_addr_in,
   input wire logic [`CPC_REG_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [`CPC_REG_W-1:0] reg_rdata_out
);
   default clocking dclk @(posedge mclk_in); endclocking
   default disable iff (!rst_b_in);
   ctrl_s ctrl_q;
   // Memory command classes and the CPU take
   wire line_op = mem_cmd_out.req && mem_cmd_out.mask == `CPC_MASK_ALL;
   wire word_wr = mem_cmd_out.req && mem_cmd_out.we && !line_op;
   wire take = cpu_req_in && cpu_ready_out;
   // Policy shadow; only valid because policy changes happen while idle
   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) ctrl_q <= ctrl_s'(`CPC_CTRL_RST);
      else if (reg_wr_in && reg_addr_in == `CPC_CTRL_OFS) ctrl_q <= ctrl_s'(reg_wdata_in[`CPC_CTRL_W-1:0]);
   end
   AST_RESET_IDLE: assert property ($rose(rst_b_in) |-> cpu_ready_out && !mem_cmd_out.req)
      else $error("not idle after reset");
   AST_WT_STALL: assert property (word_wr |-> !cpu_ready_out && !cpu_done_out)
      else $error("cpu free during word write");
   AST_WT_FORWARD: assert property (take && cpu_cmd_in.we && !ctrl_q.cb |-> ##[2:300] word_wr)
      else $error("store not forwarded");
   AST_CB_LINES: assert property (ctrl_q.cb && ctrl_q.wa && mem_cmd_out.req |-> line_op)
      else $error("word write in copy-back");
   AST_WB_FILL: assert property (line_op && mem_cmd_out.we && mem_ack_in |=> line_op && !mem_cmd_out.we)
      else $error("write-back without fill");
   AST_FILL_WHOLE: assert property (mem_cmd_out.req && !mem_cmd_out.we |-> line_op)
      else $error("partial fill");
   AST_CMD_HOLD: assert property (mem_cmd_out.req && !mem_ack_in |=> $stable(mem_cmd_out))
      else $error("command changed before ack");
   AST_DEMAND: assert property ($rose(mem_cmd_out.req) && !ctrl_q.pf |-> $past(cpu_ready_out) == 1'h0)
      else $error("request without miss");
   COV_WB: cover property (line_op && mem_cmd_out.we && mem_ack_in);
   COV_WORD: cover property (word_wr && mem_ack_in);
   COV_PF: cover property ($rose(mem_cmd_out.req) && $past(cpu_ready_out));
endmodule // cpc_checker

bind cache_policy_controller cpc_checker chk (.mclk_in, .rst_b_in, .cpu_req_in, .cpu_cmd_in, .cpu_ready_out,
   .cpu_done_out, .cpu_rdata_out, .mem_cmd_out, .mem_ack_in, .mem_rline_in, .reg_addr_in, .reg_wdata_in,
   .reg_wr_in, .reg_rd_in, .reg_rdata_out);

// [bench/cache_policy_controller_tb.sv]
// Self-checking bench of the cache policy controller
`timescale 1ns/1ps
`include "cpc_defs.svh"
module cache_policy_controller_tb
   import cpc_pkg::*;
;
   logic mclk_in = 1'h0, rst_b_in = 1'h0, cpu_req_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
   logic cpu_ready_out, cpu_done_out, mem_ack_in;
   logic [31:0] cpu_rdata_out, reg_rdata_out, got, lat, reg_wdata_in = '0, bad_count = '0, n_tests = '0, cyc = '0;
   logic [7:0] reg_addr_in = '0, nfill = '0, nwb = '0, nww = '0;
   logic [3:0] ww_mask, mlat = 4'h3;
   logic [127:0] mem_rline_in, wr_data;
   cpu_cmd_s cpu_cmd_in = '0;
   mem_cmd_s mem_cmd_out;
   cache_policy_controller uut (.mclk_in, .rst_b_in, .cpu_req_in, .cpu_cmd_in, .cpu_ready_out, .cpu_done_out,
      .cpu_rdata_out, .mem_cmd_out, .mem_ack_in, .mem_rline_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out);
   cpc_mem_model far (.mclk_in, .rst_b_in, .cmd_in(mem_cmd_out), .lat_in(mlat), .ack_out(mem_ack_in),
      .rline_out(mem_rline_in));
   always #12.5 mclk_in = ~mclk_in;
   // Tally acknowledged transfers; hang guard last so nothing follows it
   always @(posedge mclk_in) begin
      cyc <= cyc + 32'h1;
      if (mem_ack_in && mem_cmd_out.req) begin
         if (!mem_cmd_out.we) nfill++;
         else if (mem_cmd_out.mask == 4'hF) nwb++;
         else nww++;
         if (mem_cmd_out.we) wr_data = mem_cmd_out.data;
         ww_mask = mem_cmd_out.mask;
      end
      if (cyc == 32'h4E20) begin
         bad_count++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Transfer counts {fills, write-backs, word writes}, cleared after each look
   task automatic traf(input logic [23:0] e);
      chk({8'h0, nfill, nwb, nww}, {8'h0, e});
      {nfill, nwb, nww} = '0;
   endtask
   task automatic rg(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_wr_in <= wr;
      reg_rd_in <= !wr;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge mclk_in);
      reg_wr_in <= 1'h0;
      reg_rd_in <= 1'h0;
      @(negedge mclk_in);
      got = reg_rdata_out;
   endtask
   // Request held until taken; lat counts cycles from take to done
   task automatic cpu(input logic we, input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      cpu_req_in <= 1'h1;
      cpu_cmd_in <= {we, a, d};
      do @(negedge mclk_in); while (cpu_ready_out !== 1'h1);
      @(posedge mclk_in);
      cpu_req_in <= 1'h0;
      lat = '0;
      do begin
         @(negedge mclk_in);
         lat++;
      end while (cpu_done_out !== 1'h1);
      got = cpu_rdata_out;
   endtask
   // Two ways filled, first one touched again, third line decides the victim
   task automatic repl(input logic [31:0] c, input logic [31:0] s, input logic [31:0] keep);
      rg(1'h1, `CPC_CTRL_OFS, c);
      cpu(1'h0, s, '0);
      cpu(1'h0, s + 32'h100, '0);
      cpu(1'h0, s, '0);
      cpu(1'h0, s + 32'h200, '0);
      cpu(1'h0, s + keep, '0);
      chk(lat, 32'h2);
      traf(24'h030000);
      cpu(1'h0, s + 32'h100 - keep, '0);
      traf(24'h010000);
   endtask
   task automatic finish_test;
      if (bad_count == '0 && n_tests > '0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge mclk_in);
      rst_b_in <= 1'h1;
      rg(1'h0, `CPC_CTRL_OFS, '0);
      chk(got, 32'h2);
      rg(1'h0, 8'h10, '0);
      chk(got, 32'h0);
      cpu(1'h0, 32'h104, '0);
      chk(got, 32'h10000010);
      traf(24'h010000);
      cpu(1'h0, 32'h104, '0);
      traf(24'h0);
      cpu(1'h1, 32'h104, 32'hCAFE0001);
      traf(24'h000001);
      chk({28'h0, ww_mask}, 32'h2);
      chk(wr_data[31:0], 32'hCAFE0001);
      chk({31'h0, lat > 32'h2}, 32'h1);
      rg(1'h1, `CPC_CTRL_OFS, 32'h0);
      cpu(1'h1, 32'h214, 32'hBEEF0002);
      traf(24'h000001);
      cpu(1'h0, 32'h214, '0);
      traf(24'h010000);
      chk(got, 32'hBEEF0002);
      rg(1'h1, `CPC_CTRL_OFS, 32'h3);
      cpu(1'h1, 32'h104, 32'h5EED0003);
      traf(24'h0);
      chk(lat, 32'h2);
      cpu(1'h0, 32'h1104, '0);
      traf(24'h010100);
      chk(wr_data[63:32], 32'h5EED0003);
      cpu(1'h0, 32'h104, '0);
      traf(24'h010000);
      chk(got, 32'h5EED0003);
      cpu(1'h1, 32'h304, 32'hF00D0004);
      traf(24'h010000);
      cpu(1'h0, 32'h304, '0);
      chk(got, 32'hF00D0004);
      repl(32'h7, 32'h50, 32'h0);
      repl(32'hB, 32'h60, 32'h100);
      rg(1'h1, `CPC_CTRL_OFS, 32'hF);
      cpu(1'h0, 32'h70, '0);
      cpu(1'h0, 32'h170, '0);
      cpu(1'h0, 32'h270, '0);
      traf(24'h030000);
      cpu(1'h0, 32'h270, '0);
      chk(lat, 32'h2);
      rg(1'h1, `CPC_CTRL_OFS, 32'h12);
      mlat <= 4'h0;
      cpu(1'h0, 32'h480, '0);
      repeat (10) @(posedge mclk_in);
      traf(24'h020000);
      cpu(1'h0, 32'h494, '0);
      chk(lat, 32'h2);
      rg(1'h0, `CPC_HITS_OFS, '0);
      chk(got, 32'hA);
      rg(1'h0, `CPC_MISS_OFS, '0);
      chk(got, 32'h12);
      finish_test();
   end
endmodule // cache_policy_controller_tb
